// *** hw/scr_conversion_readout.sv ***
// Conversion start, busy flag and 16-bit serial result readout of a SAR converter.
// Assumes an analog core supplying the result word on the system clock and a
// host driving the convert, chip-select, clock-source and bit-clock pins.
//
// How it works
// - idle converter starts a conversion and holds the sample on a convert falling edge
// - convert edges during a conversion are ignored
// - chip select does not gate the start of a conversion
// - busy falls at start and stays low until conversion completes
// - busy rises 90 ns after the 18 us conversion completes
// - internal mode sends previous result during the current conversion, driving bit clock
// - result is 16-bit two's complement, most significant bit first
// - internal mode holds each data bit across both bit-clock edges
// - busy stays low for the whole internal transmission
// - first internal rising edge 2.0 us after start, period 0.6 to 0.85 us
// - busy rises at most 5 us after the last internal falling edge
// - result copied to the output shift word just before busy rises
// - external mode shifts on the host-supplied bit clock
// - chip select high disables data, busy and internal bit-clock drivers
// - clock source select high takes the external bit clock, low the internal
// - internal mode keeps data and bit clock low outside transmission
// - external first rising edge starts the word, bits valid at falling edges
`timescale 1ns/1ps
`default_nettype none

module scr_conversion_readout (
	// System
	input wire logic clock,
	input wire logic reset,
	// Host pins
	input wire logic convertStart_n,
	input wire logic chipSelect_n,
	input wire logic clockSourceSelect,
	// Bit clock pin: input side is the link clock
	input wire logic serialBitClockIn,
	output logic serialBitClockOut,
	output logic serialBitClockOe_n,
	// Serial data and busy pins
	output logic serialData,
	output logic serialDataOe_n,
	output logic busy_n,
	output logic busyOe_n,
	// Analog core
	input wire logic [scr_pkg::WORD_BITS-1:0] conversionResult,
	output logic sampleHold
);
	import scr_pkg::*;

	// =====================================================
	// Pin synchronisers
	// =====================================================
	logic [1:0] convSync_r;
	logic [1:0] csSync_r;
	logic [1:0] modeSync_r;
	logic [1:0] bclkSync_r;
	logic convPrev_r;

	always_ff @(posedge clock) begin
		if (reset) begin
			convSync_r <= 2'h3;
			csSync_r <= 2'h3;
			modeSync_r <= 2'h0;
			bclkSync_r <= 2'h0;
		end else begin
			convSync_r <= {convSync_r[0], convertStart_n};
			csSync_r <= {csSync_r[0], chipSelect_n};
			modeSync_r <= {modeSync_r[0], clockSourceSelect};
			bclkSync_r <= {bclkSync_r[0], serialBitClockIn};
		end
	end

	always_ff @(posedge clock) begin
		if (reset)
			convPrev_r <= 1'b1;
		else
			convPrev_r <= convSync_r[1];
	end

	logic convFall;
	logic extMode;
	logic skipLoad;
	assign convFall = convPrev_r && !convSync_r[1];
	assign extMode = modeSync_r[1];
	// A host clock held high with the chip selected at completion keeps the old word
	assign skipLoad = extMode && bclkSync_r[1] && !csSync_r[1];

	// =====================================================
	// Conversion sequencer
	// =====================================================
	scr_state_t state_r;
	logic [CNT_W-1:0] cnt_r;
	logic busyN_r;
	logic hold_r;
	logic intMode_r;
	logic [WORD_BITS-1:0] resultWord_r;

	always_ff @(posedge clock) begin
		if (reset) begin
			state_r <= ScrIdle;
			cnt_r <= '0;
		end else begin
			case (state_r)
				ScrIdle: begin
					// Chip select plays no part here
					if (convFall) begin
						state_r <= ScrConvert;
						cnt_r <= '0;
					end
				end
				ScrConvert: begin
					// Convert edges are not looked at in this state
					if (cnt_r == CNT_W'(CONVERT_START_N_CYC - 1)) begin
						state_r <= ScrFinish;
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				ScrFinish: begin
					if (cnt_r == CNT_W'(BUSY_CYC - 1)) begin
						state_r <= ScrIdle;
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				default: begin
					state_r <= ScrIdle;
					cnt_r <= '0;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			busyN_r <= 1'b1;
			hold_r <= 1'b0;
		end else if (state_r == ScrIdle && convFall) begin
			busyN_r <= 1'b0;
			hold_r <= 1'b1;
		end else if (state_r == ScrFinish && cnt_r == CNT_W'(BUSY_CYC - 1)) begin
			busyN_r <= 1'b1;
			hold_r <= 1'b0;
		end
	end

	// Mode is frozen per conversion for the transmitter only; a mid-frame change still switches the data mux and clock enable
	always_ff @(posedge clock) begin
		if (reset)
			intMode_r <= 1'b0;
		else if (state_r == ScrIdle && convFall)
			intMode_r <= !extMode;
	end

	// Output word changes only at completion, so the link side sees it static
	always_ff @(posedge clock) begin
		if (reset)
			resultWord_r <= WORD_RST;
		else if (state_r == ScrConvert && cnt_r == CNT_W'(CONVERT_START_N_CYC - 1) && !skipLoad)
			resultWord_r <= conversionResult;
	end

	// =====================================================
	// Internal bit clock transmitter
	// =====================================================
	logic txOn_r;
	logic [PH_W-1:0] phase_r;
	logic [3:0] bitIdx_r;
	logic intClk_r;
	logic intData_r;

	always_ff @(posedge clock) begin
		if (reset) begin
			txOn_r <= 1'b0;
			phase_r <= '0;
			bitIdx_r <= 4'h0;
			intData_r <= 1'b0;
		end else if (!txOn_r) begin
			if (state_r == ScrConvert && intMode_r && cnt_r == CNT_W'(LEAD_CYC - 1)) begin
				txOn_r <= 1'b1;
				phase_r <= '0;
				bitIdx_r <= 4'h0;
				intData_r <= resultWord_r[WORD_BITS-1];
			end else begin
				intData_r <= 1'b0;
			end
		end else if (phase_r == PH_W'(PERIOD_CYC - 1)) begin
			phase_r <= '0;
			bitIdx_r <= bitIdx_r + 1'b1;
			if (bitIdx_r == 4'(WORD_BITS - 1)) begin
				txOn_r <= 1'b0;
				intData_r <= 1'b0;
			end else begin
				// Data moves only at a period boundary, as here, well clear of both clock edges
				intData_r <= resultWord_r[4'(WORD_BITS - 2) - bitIdx_r];
			end
		end else begin
			phase_r <= phase_r + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset)
			intClk_r <= 1'b0;
		else if (txOn_r && phase_r == PH_W'(SETUP_CYC - 1))
			intClk_r <= 1'b1;
		else if (phase_r == PH_W'(SETUP_CYC + HIGH_CYC - 1))
			intClk_r <= 1'b0;
	end

	// =====================================================
	// Pin drivers
	// =====================================================
	logic dataOeN_r;
	logic clkOeN_r;

	always_ff @(posedge clock) begin
		if (reset) begin
			dataOeN_r <= 1'b1;
			clkOeN_r <= 1'b1;
		end else begin
			dataOeN_r <= csSync_r[1];
			clkOeN_r <= csSync_r[1] || extMode;
		end
	end

	// =====================================================
	// External bit clock domain
	// =====================================================
	logic [1:0] linkRstSync_r;
	logic [1:0] linkCsSync_r;
	logic [1:0] linkModeSync_r;
	logic [3:0] linkIdx_r;
	logic linkData_r;

	always_ff @(posedge serialBitClockIn) begin
		linkRstSync_r <= {linkRstSync_r[0], reset};
		linkCsSync_r <= {linkCsSync_r[0], chipSelect_n};
		linkModeSync_r <= {linkModeSync_r[0], clockSourceSelect};
	end

	// The word is read across domains only while it is static: it changes
	// at completion, when the host keeps this clock still.
	always_ff @(posedge serialBitClockIn) begin
		if (linkRstSync_r[1]) begin
			linkIdx_r <= 4'h0;
			linkData_r <= 1'b0;
		end else if (linkModeSync_r[1] && !linkCsSync_r[1]) begin
			linkData_r <= resultWord_r[4'(WORD_BITS - 1) - linkIdx_r];
			linkIdx_r <= linkIdx_r + 1'b1;
		end
	end

	assign serialBitClockOut = intClk_r;
	assign serialBitClockOe_n = clkOeN_r;
	assign serialData = extMode ? linkData_r : intData_r;
	assign serialDataOe_n = dataOeN_r;
	assign busy_n = busyN_r;
	assign busyOe_n = dataOeN_r;
	assign sampleHold = hold_r;

	// =====================================================
	// Checks
	// =====================================================
	localparam int A_BUSY = BUSY_CYC;
	localparam int A_LOW = CONVERT_START_N_CYC + BUSY_CYC;
	localparam int A_FIRST = FIRST_CYC;
	localparam int A_TAIL = TAIL_CYC;
	localparam int A_PERIOD = PERIOD_CYC;
	logic [CNT_W-1:0] lowCnt_r;
	logic [9:0] tailCnt_r;

	always_ff @(posedge clock) begin
		if (reset)
			lowCnt_r <= '0;
		else
			lowCnt_r <= busyN_r ? '0 : lowCnt_r + 1'b1;
	end

	always_ff @(posedge clock) begin
		if (reset || txOn_r)
			tailCnt_r <= '0;
		else if (!busyN_r && tailCnt_r != 10'h3ff)
			tailCnt_r <= tailCnt_r + 1'b1;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	start_busy_a: assert property (state_r == ScrIdle && convFall |=> !busyN_r && hold_r)
		else $error("conversion did not start on convert fall");
	ignore_convert_start_n_a: assert property (state_r == ScrConvert && convFall
		&& cnt_r != CNT_W'(CONVERT_START_N_CYC - 1) |=> cnt_r == $past(cnt_r) + 1'b1)
		else $error("convert edge disturbed a running conversion");
	cs_indep_a: assert property (state_r == ScrIdle && convFall && csSync_r[1] |=> state_r == ScrConvert)
		else $error("chip select blocked a conversion");
	busy_len_a: assert property ($rose(busyN_r) |-> lowCnt_r == CNT_W'(A_LOW))
		else $error("busy low time wrong");
	first_edge_a: assert property ($rose(intClk_r) && bitIdx_r == 4'h0 |-> cnt_r == CNT_W'(A_FIRST))
		else $error("first internal clock edge mistimed");
	idle_low_a: assert property (!txOn_r |-> !intData_r && !intClk_r)
		else $error("internal data or clock not low when idle");
	bit_stable_a: assert property ($changed(intClk_r) |-> $stable(intData_r))
		else $error("data moved on a clock edge");
	busy_frame_a: assert property (txOn_r |-> !busyN_r)
		else $error("busy high during transmission");
	tail_gap_a: assert property ($rose(busyN_r) && intMode_r |-> tailCnt_r <= 10'(A_TAIL))
		else $error("busy rose too late after last clock");
	word_load_a: assert property (state_r == ScrConvert && cnt_r == CNT_W'(CONVERT_START_N_CYC - 1) && !skipLoad
		|=> resultWord_r == $past(conversionResult) ##A_BUSY $rose(busyN_r))
		else $error("result not loaded before busy rise");
	oe_follow_a: assert property (csSync_r[1] |=> dataOeN_r && clkOeN_r)
		else $error("outputs driven while deselected");
	clk_period_a: assert property ($rose(intClk_r) && bitIdx_r != 4'hf
		|-> ##A_PERIOD $rose(intClk_r))
		else $error("internal clock period wrong");
	ext_quiet_a: assert property (!intMode_r |-> !txOn_r && !intClk_r)
		else $error("internal clock ran in external mode");
	tx_end_a: assert property ($fell(txOn_r) |-> state_r == ScrConvert)
		else $error("transmission outlived the conversion");

	// =====================================================
	// Coverage
	// =====================================================
	int_frame_c: cover property ($fell(txOn_r) ##[1:1000] $rose(busyN_r));
	ext_convert_start_n_c: cover property (state_r == ScrIdle && convFall && extMode);
	skip_load_c: cover property (state_r == ScrConvert && skipLoad);
	cs_off_c: cover property (state_r == ScrIdle && convFall && csSync_r[1]);
	ignored_convert_start_n_c: cover property (state_r == ScrConvert && convFall);

endmodule // scr_conversion_readout

`default_nettype wire

// *** hw/scr_pkg.sv ***
// Constants shared by the conversion-start and serial readout logic.
// Assumes a 125 MHz system clock; all cycle counts derive from it.
`default_nettype none

package scr_pkg;

	// =====================================================
	// Clock and word
	// =====================================================
	localparam int CLK_NS = 8;
	localparam int WORD_BITS = 16;
	localparam int CNT_W = 12;
	localparam int PH_W = 7;

	// =====================================================
	// Conversion timing
	// =====================================================
	// Typical conversion time, well under the 20 us ceiling
	localparam int CONVERT_START_N_NS = 18000;
	localparam int CONVERT_START_N_CYC = CONVERT_START_N_NS / CLK_NS;
	// Completion to busy release, longest figure so round down
	localparam int BUSY_RISE_NS = 90;
	localparam int BUSY_CYC = BUSY_RISE_NS / CLK_NS;

	// =====================================================
	// Internal bit clock timing
	// =====================================================
	localparam int FIRST_EDGE_NS = 2000;
	localparam int FIRST_CYC = FIRST_EDGE_NS / CLK_NS;
	// Period chosen inside 0.6..0.85 us so the busy tail stays under 5 us
	localparam int BIT_PERIOD_NS = 752;
	localparam int PERIOD_CYC = BIT_PERIOD_NS / CLK_NS;
	localparam int HIGH_NS = 376;
	localparam int HIGH_CYC = HIGH_NS / CLK_NS;
	// Data leads the rising edge by this much
	localparam int SETUP_NS = 184;
	localparam int SETUP_CYC = SETUP_NS / CLK_NS;
	localparam int LEAD_CYC = FIRST_CYC - SETUP_CYC;
	// Longest gap from the last falling bit-clock edge to busy release
	localparam int TAIL_NS = 5000;
	localparam int TAIL_CYC = TAIL_NS / CLK_NS;

	// =====================================================
	// Reset values
	// =====================================================
	localparam logic [WORD_BITS-1:0] WORD_RST = 16'h0000;

	typedef enum logic [1:0] {
		ScrIdle,
		ScrConvert,
		ScrFinish
	} scr_state_t;

endpackage

`default_nettype wire

// *** sim/scr_host_model.sv ***
// Host model: convert pulses and bursts of an external bit clock.
// Assumes the bench raises doConvert or doRead for a short while.
`timescale 1ns/1ps
`default_nettype none

module scr_host_model (
	// Requests
	input wire logic doConvert,
	input wire logic doRead,
	// Pins
	input wire logic serialData,
	output logic convertStart_n,
	output logic hostClk,
	// Result
	output logic [15:0] readWord,
	output logic readDone
);
	// =====
	// Pins
	// =====
	initial begin
		convertStart_n = 1'b1;
		hostClk = 1'b0;
		readWord = 16'h0000;
		readDone = 1'b0;
	end
	// Short low pulse keeps convert static for the rest of the conversion
	always @(posedge doConvert) begin
		convertStart_n = 1'b0;
		#100 convertStart_n = 1'b1;
	end
	// Clock stands low outside a burst, so a finished word always loads
	always @(posedge doRead) begin
		readDone = 1'b0;
		for (int i = 0; i < 16; i++) begin
			#80 hostClk = 1'b1;
			#80 readWord = {readWord[14:0], serialData};
			hostClk = 1'b0;
		end
		readDone = 1'b1;
	end
endmodule // scr_host_model

`default_nettype wire

// *** sim/tb.sv ***
// Bench: table of conversions in both clock modes, then chip-select case.
// Assumes the design in hw/ and the host model in sim/scr_host_model.sv.
`timescale 1ns/1ps
`default_nettype none

module tb;
	import scr_pkg::*;
	typedef struct packed {
		logic ext;
		logic [WORD_BITS-1:0] res;
		logic [WORD_BITS-1:0] exp;
	} scr_row_t;

	logic clock, reset, convertStart_n, chipSelect_n, clockSourceSelect, bitPin, hostClk;
	logic serialBitClockOut, serialBitClockOe_n, serialData, serialDataOe_n;
	logic busy_n, busyOe_n, sampleHold, doConvert, doRead, readDone;
	logic [WORD_BITS-1:0] conversionResult, readWord, word;
	int miscompares = 0;
	int checkCount = 0;
	int low, first;
	// Internal mode sends the word of the conversion before
	scr_row_t rows [4] = '{'{1'b1, 16'h8000, 16'h8000}, '{1'b1, 16'h7fff, 16'h7fff},
		'{1'b0, 16'ha5c3, 16'h7fff}, '{1'b0, 16'h0001, 16'ha5c3}};

	assign bitPin = serialBitClockOe_n ? hostClk : serialBitClockOut;

	scr_conversion_readout u_dut (.clock(clock), .reset(reset),
		.convertStart_n(convertStart_n), .chipSelect_n(chipSelect_n),
		.clockSourceSelect(clockSourceSelect), .serialBitClockIn(bitPin),
		.serialBitClockOut(serialBitClockOut), .serialBitClockOe_n(serialBitClockOe_n),
		.serialData(serialData), .serialDataOe_n(serialDataOe_n), .busy_n(busy_n),
		.busyOe_n(busyOe_n), .conversionResult(conversionResult), .sampleHold(sampleHold));
	scr_host_model u_host (.doConvert(doConvert), .doRead(doRead), .serialData(serialData),
		.convertStart_n(convertStart_n), .hostClk(hostClk), .readWord(readWord),
		.readDone(readDone));

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// =====
	// Tasks
	// =====
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
		checkCount++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// One conversion; again fires a second convert edge mid-conversion
	task automatic run_convert_start_n(input logic again);
		int n = 0;
		int lastRise = 0;
		int lastFall = 0;
		logic prev = 1'b0;
		logic dRise = 1'b0;
		low = 0;
		first = -1;
		word = '0;
		doConvert = 1'b1;
		@(negedge clock);
		doConvert = 1'b0;
		while (busy_n !== 1'b0 && n < 20) begin
			@(negedge clock);
			n++;
		end
		while (busy_n === 1'b0 && low < 3000) begin
			doConvert = again && low == 40;
			@(negedge clock);
			low++;
			if (low == 1) check("hold", 16'h1, 16'(sampleHold));
			if (serialBitClockOut === 1'b1 && !prev) begin
				dRise = serialData;
				word = {word[WORD_BITS-2:0], serialData};
				if (first >= 0) check("period", 16'h1, 16'(low - lastRise inside {[75:106]}));
				if (first < 0) first = low;
				lastRise = low;
			end
			if (serialBitClockOut === 1'b0 && prev) begin
				check("bit at fall", 16'(dRise), 16'(serialData));
				lastFall = low;
			end
			prev = serialBitClockOut;
		end
		check("busy low cycles", 16'h08d5, 16'(low));
		if (!clockSourceSelect) begin
			check("first rise", 16'h1, 16'(first inside {[240:260]}));
			check("tail", 16'h1, 16'(low - lastFall <= 625));
		end
		repeat (900) @(negedge clock);
	endtask

	// =====
	// Main
	// =====
	initial begin
		reset = 1'b1;
		doConvert = 1'b0;
		doRead = 1'b0;
		chipSelect_n = 1'b0;
		clockSourceSelect = 1'b1;
		conversionResult = 16'h0000;
		// Link side resets only while its clock runs
		@(negedge clock);
		doRead = 1'b1;
		// Release before the last two rises so the link index leaves reset at zero
		repeat (14) @(posedge hostClk);
		@(negedge clock);
		reset = 1'b0;
		@(posedge readDone);
		repeat (10) @(negedge clock);
		doRead = 1'b0;
		check("busy reset", 16'h1, 16'(busy_n));
		check("hold reset", 16'h0, 16'(sampleHold));
		foreach (rows[i]) begin
			clockSourceSelect = rows[i].ext;
			conversionResult = rows[i].res;
			repeat (4) @(negedge clock);
			run_convert_start_n(1'b0);
			if (rows[i].ext) begin
				doRead = 1'b1;
				@(posedge readDone);
				@(negedge clock);
				doRead = 1'b0;
				word = readWord;
				check("clock oe ext", 16'h1, 16'(serialBitClockOe_n));
			end else begin
				check("idle lines", 16'h0, 16'({serialData, serialBitClockOut}));
				check("clock oe int", 16'h0, 16'(serialBitClockOe_n));
			end
			check("word", rows[i].exp, word);
		end
		chipSelect_n = 1'b1;
		repeat (4) @(negedge clock);
		run_convert_start_n(1'b1);
		check("outputs off", 16'h7, 16'({serialDataOe_n, busyOe_n, serialBitClockOe_n}));
		check("no restart", 16'h0, 16'(sampleHold));
		chipSelect_n = 1'b0;
		repeat (4) @(negedge clock);
		check("outputs on", 16'h0, 16'({serialDataOe_n, busyOe_n}));
		finish_test();
	end

	// Run takes about 17000 clocks; this limit is over four times that
	initial begin
		#600000;
		miscompares++;
		$display("MISMATCH watchdog expected finish seen timeout");
		finish_test();
	end
endmodule // tb

`default_nettype wire
